// File: rtl/uhd_map.vh
`ifndef UHD_MAP_VH
`define UHD_MAP_VH

// ----------------------------------------
// register word offsets (byte address)
// ----------------------------------------
`define UHD_CMD_OFFSET      8'h20
`define UHD_STS_OFFSET      8'h24
`define UHD_INTR_OFFSET     8'h28

// ----------------------------------------
// field positions
// ----------------------------------------
`define UHD_ITC_LSB         16
`define UHD_ITC_MSB         23
`define UHD_LRST_BIT        7
`define UHD_DOOR_BIT        6
`define UHD_ASE_BIT         5
`define UHD_IAA_BIT         5
`define UHD_ASYNC_ADVANCE_IRQ_ENABLE_BIT        5
`define UHD_HALT_BIT        12

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define UHD_ITC_RESET       8'h08
`define UHD_CLK_PERIOD_NS   10
`define UHD_UFRAME_NS       125000
`define UHD_UFRAME_CYCLES   (`UHD_UFRAME_NS / `UHD_CLK_PERIOD_NS)
`define UHD_LRST_CYCLES     16

`endif

// File: rtl/uhd_thresh_gate.v
`timescale 1ns/1ps
`include "uhd_map.vh"
// ----------------------------------------
// interrupt threshold pacing
// ----------------------------------------
module uhd_thresh_gate
#(
    parameter UFRAME_CYCLES = `UHD_UFRAME_CYCLES
)
(
    input  wire       clk_in,
    input  wire       sys_rst_in,
    input  wire       core_rst_in,
    input  wire [7:0] itc_in,
    input  wire       pending_in,
    output reg        irq_out
);

    reg  [31:0] cyc_q;
    reg  [7:0]  uf_q;
    wire        uf_tick;
    wire [7:0]  limit;

    // reserved code 00h treated as one microframe
    assign limit   = (itc_in == 8'h00) ? 8'h01 // [RULE_11]
                                       : itc_in; // [RULE_01]
    assign uf_tick = (cyc_q == UFRAME_CYCLES - 1);

    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            cyc_q   <= 32'h0;
            uf_q    <= 8'h00;
            irq_out <= 1'b0;
        end
        else if (core_rst_in)
        begin
            cyc_q   <= 32'h0;
            uf_q    <= 8'h00;
            irq_out <= 1'b0;
        end
        else
        begin
            cyc_q <= uf_tick ? 32'h0 : cyc_q + 32'h1;
            if (!pending_in)
                irq_out <= 1'b0;
            if (uf_tick)
            begin
                if (uf_q + 8'h01 >= limit)
                begin
                    uf_q <= 8'h00; // [RULE_12]
                    if (pending_in)
                        irq_out <= 1'b1; // [RULE_08]
                end
                else
                begin
                    uf_q <= uf_q + 8'h01;
                end
            end
        end
    end

endmodule // uhd_thresh_gate

// File: rtl/uhd_cmd_doorbell.v
`timescale 1ns/1ps
`include "uhd_map.vh"
// What this block does
// (RULE_01) threshold sets max irq rate: 08h/10h/20h/40h = 8/16/32/64 uframes
// (RULE_02) software changes the threshold only while the halted flag reads one.
// (RULE_03) light reset is optional; if absent its bit reads zero.
// (RULE_04) light reset bit reads one while in progress, zero when done.
// (RULE_05) light reset resets the core only, not port state or routing.
// (RULE_06) software rings the doorbell by writing one to bit 6.
// (RULE_07) after cache eviction the controller sets the async advance flag.
// (RULE_08) flag with its enable raises an irq at the next threshold boundary.
// (RULE_09) doorbell self-clears only after the advance flag is set.
// (RULE_10) software never rings the doorbell with the async schedule off.
// (RULE_11) threshold bits 23:16 reset 08h; 01h/02h/04h = 1/2/4; 00h reserved.
// (RULE_12) pending irqs release when the uframe counter hits the threshold.
module uhd_cmd_doorbell
#(
    parameter LRST_IMPL     = 1,
    parameter LRST_CYCLES   = `UHD_LRST_CYCLES,
    parameter UFRAME_CYCLES = `UHD_UFRAME_CYCLES
)
(
    input  wire        clk_in,
    input  wire        sys_rst_in,
    input  wire        wr_en_in,
    input  wire        rd_en_in,
    input  wire [7:0]  addr_in,
    input  wire [31:0] wdata_in,
    input  wire        evict_done_in,
    input  wire        halted_in,
    output reg  [31:0] rdata_out,
    output reg         evict_req_out,
    output reg         core_rst_out,
    output reg         irq_out
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg  [7:0]  itc_q;
    reg         door_q;
    reg         ase_q;
    reg         iaa_q;
    reg         async_advance_irq_enable_q;
    reg  [15:0] lrst_cnt_q;
    reg         lrst_q;
    reg  [31:0] rdata_d;
    wire        cmd_wr;
    wire        sts_wr;
    wire        int_wr;
    wire        gate_irq;
    wire        lrst_start;
    wire        lrst_last;
    wire        core_busy;
    wire        door_ring;
    wire        flag_clr;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // one compare shared by all write strobes
    function reg_hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            reg_hit = (addr == offset);
        end
    endfunction

    assign cmd_wr     = wr_en_in && reg_hit(addr_in, `UHD_CMD_OFFSET);
    assign sts_wr     = wr_en_in && reg_hit(addr_in, `UHD_STS_OFFSET);
    assign int_wr     = wr_en_in && reg_hit(addr_in, `UHD_INTR_OFFSET);
    assign lrst_start = cmd_wr && wdata_in[`UHD_LRST_BIT] && (LRST_IMPL != 0);
    assign lrst_last  = lrst_q && (lrst_cnt_q == 16'h0001);
    assign core_busy  = lrst_q || lrst_start;
    assign door_ring  = cmd_wr && wdata_in[`UHD_DOOR_BIT];
    assign flag_clr   = sts_wr && wdata_in[`UHD_IAA_BIT];

    // ----------------------------------------
    // light reset sequencer
    // ----------------------------------------
    // fixed length; software polls the bit, no completion interrupt
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            lrst_q       <= 1'b0;
            lrst_cnt_q   <= 16'h0000;
            core_rst_out <= 1'b0;
        end
        else
        begin
            if (lrst_start)
            begin
                lrst_q     <= 1'b1; // [RULE_04]
                lrst_cnt_q <= LRST_CYCLES[15:0];
            end
            else if (lrst_q)
            begin
                lrst_cnt_q <= lrst_cnt_q - 16'h0001;
                if (lrst_last)
                    lrst_q <= 1'b0; // [RULE_04]
            end
            // core only: interrupt enable kept, ports untouched
            core_rst_out <= lrst_start || (lrst_q && !lrst_last); // [RULE_05]
        end
    end

    // ----------------------------------------
    // command register
    // ----------------------------------------
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            itc_q <= `UHD_ITC_RESET; // [RULE_11]
            ase_q <= 1'b0;
        end
        else if (core_busy)
        begin
            itc_q <= `UHD_ITC_RESET; // [RULE_05]
            ase_q <= 1'b0;
        end
        else if (cmd_wr)
        begin
            // undefined unless halted; written anyway [RULE_02]
            itc_q <= wdata_in[`UHD_ITC_MSB:`UHD_ITC_LSB]; // [RULE_01]
            ase_q <= wdata_in[`UHD_ASE_BIT];
        end
    end

    // ----------------------------------------
    // doorbell and advance flag
    // ----------------------------------------
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            door_q        <= 1'b0;
            iaa_q         <= 1'b0;
            evict_req_out <= 1'b0;
        end
        else if (core_busy)
        begin
            door_q        <= 1'b0; // [RULE_05]
            iaa_q         <= 1'b0;
            evict_req_out <= 1'b0;
        end
        else
        begin
            evict_req_out <= door_q && !iaa_q && !evict_done_in;
            // set wins over a same-cycle write-one-to-clear
            if (door_q && evict_done_in)
                iaa_q <= 1'b1; // [RULE_07]
            else if (flag_clr)
                iaa_q <= 1'b0;
            // a fresh ring wins; clear only once flag already visible
            if (door_ring)
                door_q <= 1'b1; // [RULE_06] [RULE_10]
            else if (door_q && iaa_q)
                door_q <= 1'b0; // [RULE_09]
        end
    end

    // ----------------------------------------
    // interrupt enable
    // ----------------------------------------
    // left alone by a light reset so the driver need not re-arm it
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            async_advance_irq_enable_q <= 1'b0;
        else if (int_wr)
            async_advance_irq_enable_q <= wdata_in[`UHD_ASYNC_ADVANCE_IRQ_ENABLE_BIT];
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always @*
    begin
        rdata_d = 32'h0000_0000;
        case (addr_in)
        `UHD_CMD_OFFSET:
        begin
            rdata_d[`UHD_ITC_MSB:`UHD_ITC_LSB] = itc_q;
            rdata_d[`UHD_LRST_BIT] = lrst_q && (LRST_IMPL != 0); // [RULE_03]
            rdata_d[`UHD_DOOR_BIT] = door_q;
            rdata_d[`UHD_ASE_BIT]  = ase_q;
        end
        `UHD_STS_OFFSET:
        begin
            rdata_d[`UHD_IAA_BIT]  = iaa_q;
            rdata_d[`UHD_HALT_BIT] = halted_in;
        end
        `UHD_INTR_OFFSET:
            rdata_d[`UHD_ASYNC_ADVANCE_IRQ_ENABLE_BIT] = async_advance_irq_enable_q;
        default:
            rdata_d = 32'h0000_0000;
        endcase
    end

    // held until the next read so slow software sees a stable word
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            rdata_out <= 32'h0000_0000;
        else if (rd_en_in)
            rdata_out <= rdata_d;
    end

    // ----------------------------------------
    // interrupt pacing
    // ----------------------------------------
    uhd_thresh_gate
    #(
        .UFRAME_CYCLES (UFRAME_CYCLES)
    )
    u_gate
    (
        .clk_in      (clk_in),
        .sys_rst_in  (sys_rst_in),
        .core_rst_in (core_rst_out),
        .itc_in      (itc_q),
        .pending_in  (iaa_q && async_advance_irq_enable_q), // [RULE_08]
        .irq_out     (gate_irq)
    );

    // ----------------------------------------
    // interrupt output
    // ----------------------------------------
    // extra stage keeps the top output straight from a flop
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            irq_out <= 1'b0;
        else
            irq_out <= gate_irq;
    end

endmodule // uhd_cmd_doorbell

// File: sim/uhd_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// core side: cache eviction answers
// ----------------------------------------
module uhd_core_model
(
    input  wire       clk_in,
    input  wire       req_in,
    input  wire [3:0] lat_in,
    output logic      done_out
);
    logic [3:0] cnt_q = 4'h0;
    logic       sent_q = 1'h0;
    initial done_out = 1'h0;
    // one pulse per request: a held request is never answered twice
    always @(posedge clk_in)
    begin
        done_out <= 1'h0;
        if (!req_in)
        begin
            cnt_q <= 4'h0;
            sent_q <= 1'h0;
        end
        else if (!sent_q && cnt_q == lat_in)
        begin
            done_out <= 1'h1;
            sent_q <= 1'h1;
        end
        else if (!sent_q)
            cnt_q <= cnt_q + 4'h1;
    end
endmodule // uhd_core_model

// File: sim/uhd_cmd_doorbell_assertions.sv
`timescale 1ns/1ps
module uhd_cmd_doorbell_chk
#(
    parameter LRST_IMPL = 1
)
(
    input wire        clk_in,
    input wire        sys_rst_in,
    input wire        wr_en_in,
    input wire        rd_en_in,
    input wire [7:0]  addr_in,
    input wire [31:0] wdata_in,
    input wire        evict_done_in,
    input wire        halted_in,
    input wire [31:0] rdata_out,
    input wire        evict_req_out,
    input wire        core_rst_out,
    input wire        irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    wire cmd_wr = wr_en_in && addr_in == 8'h20;
    wire cmd_rd = rd_en_in && addr_in == 8'h20;
    sequence door_ring;
        cmd_wr && wdata_in[6] && !wdata_in[7] && !core_rst_out;
    endsequence
    sequence lrst_go;
        LRST_IMPL != 0 && cmd_wr && wdata_in[7] && !core_rst_out;
    endsequence
    door_req_a: assert property (door_ring |-> ##2 evict_req_out)
        else $error("no eviction request");
    door_clear_a: assert property (
        $fell(evict_req_out) |-> $past(evict_done_in) || core_rst_out)
        else $error("doorbell cleared early");
    lrst_start_a: assert property (
        lrst_go |-> ##[1:2] core_rst_out)
        else $error("light reset not started");
    lrst_hold_a: assert property (
        $rose(core_rst_out) |-> core_rst_out[*8])
        else $error("light reset too short");
    lrst_end_a: assert property (
        $rose(core_rst_out) |-> ##[9:40] !core_rst_out)
        else $error("light reset never ends");
    lrst_absent_a: assert property (
        cmd_rd |=> LRST_IMPL != 0 || (!rdata_out[7] && !core_rst_out))
        else $error("absent light reset reads one");
    lrst_read_a: assert property (cmd_rd |=>
        rdata_out[7] == core_rst_out || core_rst_out != $past(core_rst_out))
        else $error("light reset bit wrong");
    rsvd_zero_a: assert property (cmd_rd |=>
        rdata_out[31:24] == 8'h00 && rdata_out[15:8] == 8'h00)
        else $error("reserved bits set");
    irq_drop_a: assert property (
        irq_out && wr_en_in && addr_in == 8'h28 && !wdata_in[5]
        |-> ##[1:3] !irq_out)
        else $error("irq stays when disabled");
endmodule // uhd_cmd_doorbell_chk
bind uhd_cmd_doorbell uhd_cmd_doorbell_chk #(.LRST_IMPL(LRST_IMPL)) u_chk (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .wr_en_in      (wr_en_in),
    .rd_en_in      (rd_en_in),
    .addr_in       (addr_in),
    .wdata_in      (wdata_in),
    .evict_done_in (evict_done_in),
    .halted_in     (halted_in),
    .rdata_out     (rdata_out),
    .evict_req_out (evict_req_out),
    .core_rst_out  (core_rst_out),
    .irq_out       (irq_out)
);

// File: sim/tb_usb_host_cmd_threshold_doorbell.sv
`timescale 1ns/1ps
module tb_usb_host_cmd_threshold_doorbell;
    logic        clk_in = 1'h0;
    logic        sys_rst_in = 1'h1;
    logic        wr_en_in = 1'h0;
    logic        rd_en_in = 1'h0;
    logic [7:0]  addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic        halted_in = 1'h1;
    logic [3:0]  lat = 4'h5;
    logic        evict_done_in, evict_req_out, core_rst_out, irq_out;
    logic [31:0] rdata_out, v;
    logic [31:0] rdata_nl, v_nl;
    logic        core_rst_nl;
    logic [7:0]  codes [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
    int          miscompares = 0;
    int          checked = 0;
    int          cyc = 0;
    int          n;
    always #5 clk_in = ~clk_in;
    // short microframe keeps threshold waits in tens of cycles
    uhd_cmd_doorbell #(.UFRAME_CYCLES(4)) dut (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .wr_en_in      (wr_en_in),
        .rd_en_in      (rd_en_in),
        .addr_in       (addr_in),
        .wdata_in      (wdata_in),
        .evict_done_in (evict_done_in),
        .halted_in     (halted_in),
        .rdata_out     (rdata_out),
        .evict_req_out (evict_req_out),
        .core_rst_out  (core_rst_out),
        .irq_out       (irq_out)
    );
    // same bus traffic, light reset left out
    uhd_cmd_doorbell #(.LRST_IMPL(0), .UFRAME_CYCLES(4)) dut_nl (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .wr_en_in      (wr_en_in),
        .rd_en_in      (rd_en_in),
        .addr_in       (addr_in),
        .wdata_in      (wdata_in),
        .evict_done_in (evict_done_in),
        .halted_in     (halted_in),
        .rdata_out     (rdata_nl),
        .evict_req_out (),
        .core_rst_out  (core_rst_nl),
        .irq_out       ()
    );
    uhd_core_model core (.clk_in(clk_in), .req_in(evict_req_out),
        .lat_in(lat), .done_out(evict_done_in));
    task automatic check(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        #1 wr_en_in = 1'h1;
        addr_in = a;
        wdata_in = d;
        @(posedge clk_in);
        #1 wr_en_in = 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        #1 rd_en_in = 1'h1;
        addr_in = a;
        @(posedge clk_in);
        #1 rd_en_in = 1'h0;
        v = rdata_out;
        v_nl = rdata_nl;
    endtask
    task automatic finish_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            finish_test;
        end
    end
    initial
    begin
        repeat (4) @(posedge clk_in);
        #1 sys_rst_in = 1'h0;
        rd(8'h20);
        check("cmd reset", v, 32'h0008_0000);
        rd(8'h24);
        check("sts reset", v, 32'h0000_1000);
        rd(8'h30);
        check("unmapped", v, 32'h0);
        foreach (codes[i])
        begin
            wr(8'h20, {8'h00, codes[i], 16'h0});
            rd(8'h20);
            check("itc", v, {8'h00, codes[i], 16'h0});
        end
        $display("threshold test done");
        wr(8'h20, 32'h0002_0020);
        halted_in = 1'h0;
        wr(8'h20, 32'h0002_0060);
        rd(8'h20);
        check("door held", v & 32'h40, 32'h40);
        rd(8'h24);
        check("flag not yet", v & 32'h20, 32'h0);
        for (n = 0; !evict_done_in && n < 50; n++)
            @(posedge clk_in) #1;
        repeat (40) @(posedge clk_in);
        check("irq masked", {31'h0, irq_out}, 32'h0);
        rd(8'h24);
        check("adv flag", v & 32'h1020, 32'h20);
        rd(8'h20);
        check("doorbell", v & 32'h40, 32'h0);
        wr(8'h28, 32'h20);
        for (n = 0; !irq_out && n < 12; n++)
            @(posedge clk_in) #1;
        check("irq paced", {31'h0, irq_out}, 32'h1);
        wr(8'h28, 32'h0);
        wr(8'h24, 32'h20);
        rd(8'h24);
        check("flag clear", v & 32'h20, 32'h0);
        $display("doorbell test done");
        wr(8'h28, 32'h20);
        wr(8'h20, 32'h80);
        rd(8'h20);
        check("lrst busy", v & 32'h80, 32'h80);
        check("lrst absent", v_nl & 32'h80, 32'h0);
        check("no core rst", {31'h0, core_rst_nl}, 32'h0);
        for (n = 0; core_rst_out && n < 60; n++)
            @(posedge clk_in) #1;
        rd(8'h20);
        check("lrst done", v & 32'h80, 32'h0);
        check("core reinit", v, 32'h0008_0000);
        rd(8'h28);
        check("enable kept", v, 32'h0000_0020);
        $display("light reset test done");
        finish_test;
    end
endmodule // tb_usb_host_cmd_threshold_doorbell
